// ==== common/usp_pkg.sv ====
// constants for the serial and modem pin block of one dual uart
// assumes a single 10 MHz reference clock and control bits held outside
package usp_pkg;
	// ****************************************
	// modem control bit positions
	// ****************************************
	localparam int MCR_DTR_BIT = 0;
	localparam int MCR_RTS_BIT = 1;
	localparam int MCR_OP2_BIT = 3;
	localparam int MCR_IR_BIT = 6;
	// feature control bit positions
	localparam int FEATURE_CONTROL_REG_HYST_LSB = 0;
	localparam int FEATURE_CONTROL_REG_IRINV_BIT = 2;
	localparam int FEATURE_CONTROL_REG_HDX_BIT = 3;
	// enhanced feature and interrupt enable bit positions
	localparam int EFR_ARTS_BIT = 6;
	localparam int EFR_ACTS_BIT = 7;
	localparam int IER_RX_BIT = 0;
	localparam int IER_CTS_BIT = 7;
	// ****************************************
	// timing and sizes
	// ****************************************
	localparam int CLK_HZ = 10_000_000;
	localparam int BAUD = 9600;
	localparam int CLKS_PER_BIT = CLK_HZ / BAUD; // rounds down
	localparam int IR_PULSE_NUM = 3; // infrared pulse is 3/16 of a bit
	localparam int IR_PULSE_DEN = 16;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 32;
	localparam int CNT_W = 16;
	// reset values of the line outputs
	localparam logic SERIAL_OUT_RST = 1'b1;
	localparam logic PIN_N_RST = 1'b1;
endpackage

// ==== design/usp_modem_pins.sv ====
// dual channel serial and modem pin logic with a transmit fifo per channel
// assumes synchronous pin inputs and control bits held stable by software
// Summary of operation
// - standard mode: serial output idles high, also during reset
// - infrared mode bit routes both data paths through encoder and decoder
// - infrared mode: encoder output idles low
// - infrared input idles low; feature bit optionally inverts it first
// - output-2 bit: set drives irq and output-2 low; clear floats irq
// - after reset irq is floated and output-2 is high
// - auto request-to-send needs request bit asserted and enable bit set
// - clear-to-send gates transmit when enabled; changes may interrupt
// - active-low receiver-ready shows the receive holding register state
// - active-low terminal-ready output follows its control bit
// - set-ready, carrier and ring inputs readable as general inputs

// ****************************************
// fifo
// ****************************************
module usp_fifo #(
	parameter int W = usp_pkg::DATA_W,
	parameter int D = usp_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready,
	output logic [W-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wptr_q, rptr_q;
	logic [AW:0] count_q, count_d;
	logic do_wr, do_rd, ready_q;
	// ready comes from a flop fed by the next fill level
	assign count_d = count_q + (AW+1)'(do_wr) - (AW+1)'(do_rd);
	assign wr_ready = ready_q;
	assign rd_valid = (count_q != '0);
	assign rd_data = mem[rptr_q];
	assign do_wr = wr_valid && wr_ready;
	assign do_rd = rd_valid && rd_ready;
	// storage
	always_ff @(posedge clk) begin
		if (do_wr) begin
			mem[wptr_q] <= wr_data;
		end
	end
	// pointers and fill level
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wptr_q <= '0;
			rptr_q <= '0;
			count_q <= '0;
			ready_q <= 1'b1;
		end else begin
			if (do_wr) wptr_q <= (wptr_q == AW'(D-1)) ? '0 : wptr_q + 1'b1;
			if (do_rd) rptr_q <= (rptr_q == AW'(D-1)) ? '0 : rptr_q + 1'b1;
			count_q <= count_d;
			ready_q <= (count_d != (AW+1)'(D));
		end
	end
endmodule // usp_fifo

// ****************************************
// one channel
// ****************************************
module usp_channel #(
	parameter int CPB = usp_pkg::CLKS_PER_BIT,
	parameter int DEPTH = usp_pkg::FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] modem_control_reg,
	input wire logic [7:0] feature_control_reg,
	input wire logic [7:0] enhanced_feature_reg,
	input wire logic [7:0] interrupt_enable_reg,
	input wire logic [usp_pkg::DATA_W-1:0] tx_data,
	input wire logic tx_valid,
	output logic tx_ready,
	input wire logic rx_read,
	input wire logic status_read,
	input wire logic serial_in,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic cd_n,
	input wire logic ri_n,
	output logic serial_out,
	output logic rts_n,
	output logic dtr_n,
	output logic op2_n,
	output logic irq_out,
	output logic irq_oe,
	output logic rx_ready_n,
	output logic [usp_pkg::DATA_W-1:0] rx_data,
	output logic [3:0] modem_status,
	output logic cts_delta
);
	import usp_pkg::*;
	typedef enum logic [1:0] {S_IDLE, S_START, S_DATA, S_STOP} usp_state_type;
	localparam logic [CNT_W-1:0] BIT_END = CNT_W'(CPB - 1);
	localparam logic [CNT_W-1:0] BIT_MID = CNT_W'(CPB / 2);
	localparam logic [CNT_W-1:0] IR_LEN =
		CNT_W'((CPB * IR_PULSE_NUM + IR_PULSE_DEN - 1) / IR_PULSE_DEN);
	usp_state_type tx_st_q, rx_st_q;
	logic [CNT_W-1:0] tx_cnt_q, rx_cnt_q, ir_cnt_q;
	logic [2:0] tx_idx_q, rx_idx_q;
	logic [DATA_W-1:0] tx_sh_q, rx_sh_q, f_data;
	logic f_valid, f_ready, cts_ok, tx_bit, rx_line, ir_in;
	logic rx_done, rx_full_q, rx_full_d, cts_prev_q, delta_d;

	// clear-to-send holds off a new character when auto mode is on
	assign cts_ok = !(enhanced_feature_reg[EFR_ACTS_BIT] && cts_n);
	assign f_ready = (tx_st_q == S_IDLE) && cts_ok;

	usp_fifo #(.W(DATA_W), .D(DEPTH)) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.wr_data(tx_data),
		.wr_valid(tx_valid),
		.wr_ready(tx_ready),
		.rd_data(f_data),
		.rd_valid(f_valid),
		.rd_ready(f_ready)
	);

	// transmit sequencer: start, eight data bits lsb first, stop
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			tx_st_q <= S_IDLE;
			tx_cnt_q <= '0;
			tx_idx_q <= '0;
			tx_sh_q <= '0;
		end else begin
			tx_cnt_q <= (tx_st_q == S_IDLE || tx_cnt_q == BIT_END) ?
				'0 : tx_cnt_q + 1'b1;
			case (tx_st_q)
				S_IDLE: begin
					if (f_valid && f_ready) begin
						tx_sh_q <= f_data;
						tx_st_q <= S_START;
					end
				end
				S_START: begin
					if (tx_cnt_q == BIT_END) tx_st_q <= S_DATA;
				end
				S_DATA: begin
					if (tx_cnt_q == BIT_END) begin
						tx_sh_q <= {1'b0, tx_sh_q[DATA_W-1:1]};
						tx_idx_q <= tx_idx_q + 1'b1;
						if (tx_idx_q == 3'h7) tx_st_q <= S_STOP;
					end
				end
				default: begin
					if (tx_cnt_q == BIT_END) tx_st_q <= S_IDLE;
				end
			endcase
		end
	end

	// line level of the current bit; idle and stop are mark
	assign tx_bit = (tx_st_q == S_START) ? 1'b0 :
		(tx_st_q == S_DATA) ? tx_sh_q[0] : 1'b1;

	// output pin: plain level, or short high pulse per zero bit in infrared
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			serial_out <= SERIAL_OUT_RST;
		end else if (modem_control_reg[MCR_IR_BIT]) begin
			serial_out <= !tx_bit && (tx_cnt_q < IR_LEN);
		end else begin
			serial_out <= tx_bit;
		end
	end

	// infrared decoder: optional inversion, then stretch a pulse to a bit
	assign ir_in = serial_in ^ feature_control_reg[FEATURE_CONTROL_REG_IRINV_BIT];
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ir_cnt_q <= '0;
		end else if (ir_in && modem_control_reg[MCR_IR_BIT]) begin // no false start on switch
			ir_cnt_q <= BIT_END;
		end else if (ir_cnt_q != '0) begin
			ir_cnt_q <= ir_cnt_q - 1'b1;
		end
	end
	assign rx_line = modem_control_reg[MCR_IR_BIT] ?
		!(ir_in || ir_cnt_q != '0) : serial_in;

	// receive sequencer: sample each bit at its middle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_st_q <= S_IDLE;
			rx_cnt_q <= '0;
			rx_idx_q <= '0;
			rx_sh_q <= '0;
		end else begin
			rx_cnt_q <= (rx_st_q == S_IDLE || rx_cnt_q == BIT_END) ?
				'0 : rx_cnt_q + 1'b1;
			case (rx_st_q)
				S_IDLE: begin
					if (!rx_line) rx_st_q <= S_START;
				end
				S_START: begin
					if (rx_cnt_q == BIT_MID && rx_line) rx_st_q <= S_IDLE;
					else if (rx_cnt_q == BIT_END) rx_st_q <= S_DATA;
				end
				S_DATA: begin
					if (rx_cnt_q == BIT_MID) begin
						rx_sh_q <= {rx_line, rx_sh_q[DATA_W-1:1]};
					end
					if (rx_cnt_q == BIT_END) begin
						rx_idx_q <= rx_idx_q + 1'b1;
						if (rx_idx_q == 3'h7) rx_st_q <= S_STOP;
					end
				end
				default: begin
					if (rx_cnt_q == BIT_MID) rx_st_q <= S_IDLE;
				end
			endcase
		end
	end
	assign rx_done = (rx_st_q == S_STOP) && (rx_cnt_q == BIT_MID) && rx_line;

	// holding register; a new character wins over a read in the same cycle
	assign rx_full_d = rx_done || (rx_full_q && !rx_read);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rx_full_q <= 1'b0;
			rx_ready_n <= PIN_N_RST;
			rx_data <= '0;
		end else begin
			rx_full_q <= rx_full_d;
			rx_ready_n <= !rx_full_d;
			if (rx_done) rx_data <= rx_sh_q;
		end
	end

	// modem inputs shown active high; clear-to-send change is sticky
	assign delta_d = (cts_n != cts_prev_q) || (cts_delta && !status_read);
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			modem_status <= '0;
			cts_prev_q <= 1'b1;
			cts_delta <= 1'b0;
		end else begin
			modem_status <= {!ri_n, !cd_n, !dsr_n, !cts_n};
			cts_prev_q <= cts_n;
			cts_delta <= delta_d;
		end
	end

	// request-to-send: direction control, auto flow, or plain control bit
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rts_n <= PIN_N_RST;
		end else if (feature_control_reg[FEATURE_CONTROL_REG_HDX_BIT]) begin
			rts_n <= (tx_st_q == S_IDLE);
		end else if (enhanced_feature_reg[EFR_ARTS_BIT]) begin
			rts_n <= !modem_control_reg[MCR_RTS_BIT] || rx_full_d;
		end else begin
			rts_n <= !modem_control_reg[MCR_RTS_BIT];
		end
	end

	// terminal-ready, output-2 and the interrupt pin
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			dtr_n <= PIN_N_RST;
			op2_n <= PIN_N_RST;
			irq_oe <= 1'b0;
			irq_out <= 1'b0;
		end else begin
			dtr_n <= !modem_control_reg[MCR_DTR_BIT];
			op2_n <= !modem_control_reg[MCR_OP2_BIT];
			irq_oe <= modem_control_reg[MCR_OP2_BIT];
			irq_out <= (interrupt_enable_reg[IER_RX_BIT] && rx_full_d) ||
				(interrupt_enable_reg[IER_CTS_BIT] && delta_d);
		end
	end
endmodule // usp_channel

// ****************************************
// top: reset release and two channels
// ****************************************
module usp_modem_pins #(
	parameter int CLKS_PER_BIT = usp_pkg::CLKS_PER_BIT,
	parameter int FIFO_DEPTH = usp_pkg::FIFO_DEPTH
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic [7:0] CHAN_A_MODEM_CONTROL_REG,
	input wire logic [7:0] CHAN_A_FEATURE_CONTROL_REG,
	input wire logic [7:0] CHAN_A_ENHANCED_FEATURE_REG,
	input wire logic [7:0] CHAN_A_INTERRUPT_ENABLE_REG,
	input wire logic [usp_pkg::DATA_W-1:0] CHAN_A_TX_DATA,
	input wire logic CHAN_A_TX_VALID,
	output logic CHAN_A_TX_READY,
	input wire logic CHAN_A_RX_READ,
	input wire logic CHAN_A_STATUS_READ,
	input wire logic CHAN_A_SERIAL_IN,
	input wire logic CHAN_A_CLEAR_TO_SEND_N,
	input wire logic CHAN_A_SET_READY_N,
	input wire logic CHAN_A_CARRIER_DETECT_N,
	input wire logic CHAN_A_RING_INDICATOR_N,
	output logic CHAN_A_SERIAL_OUT,
	output logic CHAN_A_REQUEST_TO_SEND_N,
	output logic CHAN_A_TERMINAL_READY_N,
	output logic CHAN_A_OUTPUT_TWO_N,
	output logic CHAN_A_IRQ_OUT,
	output logic CHAN_A_IRQ_OE,
	output logic CHAN_A_RECEIVER_READY_N,
	output logic [usp_pkg::DATA_W-1:0] CHAN_A_RX_DATA,
	output logic [3:0] CHAN_A_MODEM_STATUS,
	output logic CHAN_A_CTS_DELTA,
	input wire logic [7:0] CHAN_B_MODEM_CONTROL_REG,
	input wire logic [7:0] CHAN_B_FEATURE_CONTROL_REG,
	input wire logic [7:0] CHAN_B_ENHANCED_FEATURE_REG,
	input wire logic [7:0] CHAN_B_INTERRUPT_ENABLE_REG,
	input wire logic [usp_pkg::DATA_W-1:0] CHAN_B_TX_DATA,
	input wire logic CHAN_B_TX_VALID,
	output logic CHAN_B_TX_READY,
	input wire logic CHAN_B_RX_READ,
	input wire logic CHAN_B_STATUS_READ,
	input wire logic CHAN_B_SERIAL_IN,
	input wire logic CHAN_B_CLEAR_TO_SEND_N,
	input wire logic CHAN_B_SET_READY_N,
	input wire logic CHAN_B_CARRIER_DETECT_N,
	input wire logic CHAN_B_RING_INDICATOR_N,
	output logic CHAN_B_SERIAL_OUT,
	output logic CHAN_B_REQUEST_TO_SEND_N,
	output logic CHAN_B_TERMINAL_READY_N,
	output logic CHAN_B_OUTPUT_TWO_N,
	output logic CHAN_B_IRQ_OUT,
	output logic CHAN_B_IRQ_OE,
	output logic CHAN_B_RECEIVER_READY_N,
	output logic [usp_pkg::DATA_W-1:0] CHAN_B_RX_DATA,
	output logic [3:0] CHAN_B_MODEM_STATUS,
	output logic CHAN_B_CTS_DELTA
);
	import usp_pkg::*;
	logic [1:0] rst_sync_q;
	// reset asserts at once and releases after two clock edges
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) rst_sync_q <= 2'h0;
		else rst_sync_q <= {rst_sync_q[0], 1'b1};
	end

	// each channel sees only its own control bits
	usp_channel #(.CPB(CLKS_PER_BIT), .DEPTH(FIFO_DEPTH)) u_chan_a (
		.clk(REF_CLK), .rst_n(rst_sync_q[1]),
		.modem_control_reg(CHAN_A_MODEM_CONTROL_REG), .feature_control_reg(CHAN_A_FEATURE_CONTROL_REG),
		.enhanced_feature_reg(CHAN_A_ENHANCED_FEATURE_REG), .interrupt_enable_reg(CHAN_A_INTERRUPT_ENABLE_REG),
		.tx_data(CHAN_A_TX_DATA), .tx_valid(CHAN_A_TX_VALID),
		.tx_ready(CHAN_A_TX_READY), .rx_read(CHAN_A_RX_READ),
		.status_read(CHAN_A_STATUS_READ), .serial_in(CHAN_A_SERIAL_IN),
		.cts_n(CHAN_A_CLEAR_TO_SEND_N), .dsr_n(CHAN_A_SET_READY_N),
		.cd_n(CHAN_A_CARRIER_DETECT_N), .ri_n(CHAN_A_RING_INDICATOR_N),
		.serial_out(CHAN_A_SERIAL_OUT), .rts_n(CHAN_A_REQUEST_TO_SEND_N),
		.dtr_n(CHAN_A_TERMINAL_READY_N), .op2_n(CHAN_A_OUTPUT_TWO_N),
		.irq_out(CHAN_A_IRQ_OUT), .irq_oe(CHAN_A_IRQ_OE),
		.rx_ready_n(CHAN_A_RECEIVER_READY_N), .rx_data(CHAN_A_RX_DATA),
		.modem_status(CHAN_A_MODEM_STATUS), .cts_delta(CHAN_A_CTS_DELTA)
	);
	usp_channel #(.CPB(CLKS_PER_BIT), .DEPTH(FIFO_DEPTH)) u_chan_b (
		.clk(REF_CLK), .rst_n(rst_sync_q[1]),
		.modem_control_reg(CHAN_B_MODEM_CONTROL_REG), .feature_control_reg(CHAN_B_FEATURE_CONTROL_REG),
		.enhanced_feature_reg(CHAN_B_ENHANCED_FEATURE_REG), .interrupt_enable_reg(CHAN_B_INTERRUPT_ENABLE_REG),
		.tx_data(CHAN_B_TX_DATA), .tx_valid(CHAN_B_TX_VALID),
		.tx_ready(CHAN_B_TX_READY), .rx_read(CHAN_B_RX_READ),
		.status_read(CHAN_B_STATUS_READ), .serial_in(CHAN_B_SERIAL_IN),
		.cts_n(CHAN_B_CLEAR_TO_SEND_N), .dsr_n(CHAN_B_SET_READY_N),
		.cd_n(CHAN_B_CARRIER_DETECT_N), .ri_n(CHAN_B_RING_INDICATOR_N),
		.serial_out(CHAN_B_SERIAL_OUT), .rts_n(CHAN_B_REQUEST_TO_SEND_N),
		.dtr_n(CHAN_B_TERMINAL_READY_N), .op2_n(CHAN_B_OUTPUT_TWO_N),
		.irq_out(CHAN_B_IRQ_OUT), .irq_oe(CHAN_B_IRQ_OE),
		.rx_ready_n(CHAN_B_RECEIVER_READY_N), .rx_data(CHAN_B_RX_DATA),
		.modem_status(CHAN_B_MODEM_STATUS), .cts_delta(CHAN_B_CTS_DELTA)
	);
endmodule // usp_modem_pins

// ==== sim/usp_chk.sv ====
// checker for the serial and modem pin block, watching top ports only
// assumes a bind onto usp_modem_pins with ports matched by name
module usp_chk #(
	parameter int CLKS_PER_BIT = 16
) (
	input wire logic REF_CLK,
	input wire logic NRST,
	input wire logic [7:0] CHAN_A_MODEM_CONTROL_REG,
	input wire logic [7:0] CHAN_A_FEATURE_CONTROL_REG,
	input wire logic [7:0] CHAN_A_ENHANCED_FEATURE_REG,
	input wire logic CHAN_A_RX_READ,
	input wire logic CHAN_A_CLEAR_TO_SEND_N,
	input wire logic CHAN_A_SET_READY_N,
	input wire logic CHAN_A_CARRIER_DETECT_N,
	input wire logic CHAN_A_RING_INDICATOR_N,
	input wire logic CHAN_A_SERIAL_OUT,
	input wire logic CHAN_A_REQUEST_TO_SEND_N,
	input wire logic CHAN_A_TERMINAL_READY_N,
	input wire logic CHAN_A_OUTPUT_TWO_N,
	input wire logic CHAN_A_IRQ_OE,
	input wire logic CHAN_A_RECEIVER_READY_N,
	input wire logic [3:0] CHAN_A_MODEM_STATUS,
	input wire logic CHAN_A_CTS_DELTA,
	input wire logic [7:0] CHAN_B_MODEM_CONTROL_REG,
	input wire logic CHAN_B_SERIAL_OUT,
	input wire logic CHAN_B_OUTPUT_TWO_N,
	input wire logic CHAN_B_IRQ_OE
);
	// length of one infrared pulse in clocks
	localparam int IRP = (CLKS_PER_BIT * 3 + 15) / 16;
	logic [1:0] up_q;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (!NRST);
	// ****
	// edges since reset release, saturating at 3
	// ****
	always_ff @(posedge REF_CLK or negedge NRST) begin
		if (!NRST) up_q <= 2'h0;
		else if (up_q != 2'h3) up_q <= up_q + 2'h1;
	end
	a_reset_idle: assert property (up_q != 2'h3 |->
		CHAN_A_SERIAL_OUT && CHAN_A_OUTPUT_TWO_N && !CHAN_A_IRQ_OE &&
		CHAN_A_TERMINAL_READY_N)
		else $error("outputs left idle state after reset");
	a_op2_pair: assert property (CHAN_A_OUTPUT_TWO_N != CHAN_A_IRQ_OE)
		else $error("output two and irq drive disagree");
	a_op2_b_pair: assert property (CHAN_B_OUTPUT_TWO_N != CHAN_B_IRQ_OE)
		else $error("channel b output two and irq drive disagree");
	a_op2_ctrl: assert property (up_q == 2'h3 |->
		CHAN_A_OUTPUT_TWO_N == !$past(CHAN_A_MODEM_CONTROL_REG[3]))
		else $error("output two not following its bit");
	a_dtr_ctrl: assert property (up_q == 2'h3 |->
		CHAN_A_TERMINAL_READY_N == !$past(CHAN_A_MODEM_CONTROL_REG[0]))
		else $error("terminal ready not following its bit");
	a_rts_plain: assert property (up_q == 2'h3 &&
		!$past(CHAN_A_FEATURE_CONTROL_REG[3]) &&
		!$past(CHAN_A_ENHANCED_FEATURE_REG[6]) |->
		CHAN_A_REQUEST_TO_SEND_N == !$past(CHAN_A_MODEM_CONTROL_REG[1]))
		else $error("request to send not following its bit");
	a_status_follow: assert property (up_q == 2'h3 |->
		CHAN_A_MODEM_STATUS == ~$past({CHAN_A_RING_INDICATOR_N,
		CHAN_A_CARRIER_DETECT_N, CHAN_A_SET_READY_N, CHAN_A_CLEAR_TO_SEND_N}))
		else $error("modem status not following inputs");
	a_cts_delta: assert property (up_q == 2'h3 &&
		$changed(CHAN_A_CLEAR_TO_SEND_N) |-> ##[1:2] CHAN_A_CTS_DELTA)
		else $error("clear to send change not flagged");
	a_rx_hold: assert property (!CHAN_A_RECEIVER_READY_N &&
		!CHAN_A_RX_READ |=> !CHAN_A_RECEIVER_READY_N)
		else $error("receiver ready dropped without a read");
	a_ir_pulse: assert property ($rose(CHAN_B_SERIAL_OUT) &&
		CHAN_B_MODEM_CONTROL_REG[6] && $past(CHAN_B_MODEM_CONTROL_REG[6])
		|-> ##[1:IRP] !CHAN_B_SERIAL_OUT)
		else $error("infrared pulse too long");
	a_std_start: assert property (up_q == 2'h3 &&
		$fell(CHAN_A_SERIAL_OUT) && !CHAN_A_MODEM_CONTROL_REG[6]
		|-> !CHAN_A_SERIAL_OUT [*8])
		else $error("start bit too short");
	// main scenarios reached
	c_rx: cover property (!CHAN_A_RECEIVER_READY_N);
	c_ir: cover property ($rose(CHAN_B_SERIAL_OUT));
	c_cts: cover property (CHAN_A_CTS_DELTA);
endmodule // usp_chk

// ==== sim/usp_far.sv ====
// far side model: line transceiver or infrared module of one channel
// assumes the channel runs 16 clocks a bit
module usp_far (
	input wire logic clk,
	input wire logic ir,
	input wire logic inv,
	input wire logic line_out,
	output logic line_in
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPB = 16;
	logic [7:0] q[$];
	logic [7:0] c;
	// plain line idles high
	initial line_in = 1'b1;
	// send one frame lsb first; in ir a zero is a 3 clock pulse
	task automatic send(input logic [7:0] d);
		logic [9:0] f;
		f = {1'b1, d, 1'b0};
		for (int b = 0; b < 10; b++) begin
			for (int k = 0; k < CPB; k++) begin
				@(posedge clk);
				#1;
				line_in = ir ? inv ^ (!f[b] && k < 3) : f[b];
			end
		end
		@(posedge clk);
		#1;
		line_in = ir ? inv : 1'b1;
	endtask
	// decode plain frames seen on the channel's serial output
	initial forever begin
		@(negedge line_out);
		if (!ir) begin
			repeat (CPB / 2) @(posedge clk);
			for (int b = 0; b < 8; b++) begin
				repeat (CPB) @(posedge clk);
				c[b] = line_out;
			end
			repeat (CPB) @(posedge clk);
			if (line_out) q.push_back(c);
		end
	end
endmodule // usp_far

// ==== sim/tb.sv ====
// testbench for the serial and modem pin block
// assumes 16 clocks a bit and a 32 word transmit fifo
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int CPB = 16;
	localparam logic [15:0] ROWS [6] = '{16'h0b05, 16'h0a8a, 16'h0140,
		16'h0208, 16'h0000, 16'h0b4f};
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] modem_control_reg[2], feature_control_reg[2], enhanced_feature_reg[2], interrupt_enable_reg[2], txd[2], rxd[2], m;
	logic [3:0] mp[2], ms[2];
	logic txv[2], rxr[2], str[2], si[2], txr[2], so[2], rts[2], dtr[2];
	logic op2[2], irq[2], oe[2], rr[2], cdl[2], pv;
	int n_mismatch = 0;
	int n_compared = 0;
	int k, n;
	usp_modem_pins #(.CLKS_PER_BIT(CPB), .FIFO_DEPTH(32)) u_usp_modem_pins (
		.REF_CLK(clk), .NRST(nrst),
		.CHAN_A_MODEM_CONTROL_REG(modem_control_reg[0]), .CHAN_A_FEATURE_CONTROL_REG(feature_control_reg[0]),
		.CHAN_A_ENHANCED_FEATURE_REG(enhanced_feature_reg[0]),
		.CHAN_A_INTERRUPT_ENABLE_REG(interrupt_enable_reg[0]), .CHAN_A_TX_DATA(txd[0]),
		.CHAN_A_TX_VALID(txv[0]), .CHAN_A_TX_READY(txr[0]),
		.CHAN_A_RX_READ(rxr[0]), .CHAN_A_STATUS_READ(str[0]),
		.CHAN_A_SERIAL_IN(si[0]), .CHAN_A_CLEAR_TO_SEND_N(mp[0][0]),
		.CHAN_A_SET_READY_N(mp[0][1]), .CHAN_A_CARRIER_DETECT_N(mp[0][2]),
		.CHAN_A_RING_INDICATOR_N(mp[0][3]), .CHAN_A_SERIAL_OUT(so[0]),
		.CHAN_A_REQUEST_TO_SEND_N(rts[0]), .CHAN_A_TERMINAL_READY_N(dtr[0]),
		.CHAN_A_OUTPUT_TWO_N(op2[0]), .CHAN_A_IRQ_OUT(irq[0]),
		.CHAN_A_IRQ_OE(oe[0]), .CHAN_A_RECEIVER_READY_N(rr[0]),
		.CHAN_A_RX_DATA(rxd[0]), .CHAN_A_MODEM_STATUS(ms[0]),
		.CHAN_A_CTS_DELTA(cdl[0]),
		.CHAN_B_MODEM_CONTROL_REG(modem_control_reg[1]), .CHAN_B_FEATURE_CONTROL_REG(feature_control_reg[1]),
		.CHAN_B_ENHANCED_FEATURE_REG(enhanced_feature_reg[1]),
		.CHAN_B_INTERRUPT_ENABLE_REG(interrupt_enable_reg[1]), .CHAN_B_TX_DATA(txd[1]),
		.CHAN_B_TX_VALID(txv[1]), .CHAN_B_TX_READY(txr[1]),
		.CHAN_B_RX_READ(rxr[1]), .CHAN_B_STATUS_READ(str[1]),
		.CHAN_B_SERIAL_IN(si[1]), .CHAN_B_CLEAR_TO_SEND_N(mp[1][0]),
		.CHAN_B_SET_READY_N(mp[1][1]), .CHAN_B_CARRIER_DETECT_N(mp[1][2]),
		.CHAN_B_RING_INDICATOR_N(mp[1][3]), .CHAN_B_SERIAL_OUT(so[1]),
		.CHAN_B_REQUEST_TO_SEND_N(rts[1]), .CHAN_B_TERMINAL_READY_N(dtr[1]),
		.CHAN_B_OUTPUT_TWO_N(op2[1]), .CHAN_B_IRQ_OUT(irq[1]),
		.CHAN_B_IRQ_OE(oe[1]), .CHAN_B_RECEIVER_READY_N(rr[1]),
		.CHAN_B_RX_DATA(rxd[1]), .CHAN_B_MODEM_STATUS(ms[1]),
		.CHAN_B_CTS_DELTA(cdl[1]));
	usp_far u_far_a (.clk(clk), .ir(modem_control_reg[0][6]), .inv(feature_control_reg[0][2]),
		.line_out(so[0]), .line_in(si[0]));
	usp_far u_far_b (.clk(clk), .ir(modem_control_reg[1][6]), .inv(feature_control_reg[1][2]),
		.line_out(so[1]), .line_in(si[1]));
	// ****
	// clock, compare and wait helpers
	// ****
	always #50 clk = ~clk;
	task automatic fail(input string s);
		n_mismatch++;
		$display("[ERR] %0t %s", $time, s);
	endtask
	task automatic test_done();
		if (n_mismatch == 0 && n_compared > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic cmp_b(input logic g, input logic e);
		n_compared++;
		if (g !== e) fail("bit mismatch");
	endtask
	task automatic cmp_v(input logic [7:0] g, input logic [7:0] e);
		n_compared++;
		if (g !== e) fail("value mismatch");
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	task automatic hang();
		fail("timeout");
		test_done();
	endtask
	// offer one word and hold it until taken
	task automatic push(input int ch, input logic [7:0] d);
		txd[ch] = d;
		txv[ch] = 1'b1;
		for (k = 0; txr[ch] !== 1'b1; k++) begin
			if (k > 400) hang();
			tick(1);
		end
		tick(1);
	endtask
	task automatic wait_rx(input int ch);
		for (k = 0; rr[ch] !== 1'b0; k++) begin
			if (k > 400) hang();
			tick(1);
		end
	endtask
	// ****
	// main sequence
	// ****
	initial begin
		for (int c = 0; c < 2; c++) begin
			{modem_control_reg[c], feature_control_reg[c], enhanced_feature_reg[c], interrupt_enable_reg[c], txd[c]} = {8'h0b, 32'h0};
			{txv[c], rxr[c], str[c], mp[c]} = {3'h0, 4'hf};
		end
		tick(4);
		cmp_b(so[0] & dtr[0] & rts[0] & op2[0] & rr[0], 1'b1);
		cmp_b(oe[0] | oe[1], 1'b0);
		nrst = 1'b1;
		tick(3);
		for (int i = 0; i < 6; i++) begin
			modem_control_reg[0] = ROWS[i][15:8];
			feature_control_reg[0] = {4'h0, ROWS[i][7:4]};
			mp[0] = ROWS[i][3:0];
			enhanced_feature_reg[0] = {1'b0, i[0], 6'h00};
			modem_control_reg[1] = ROWS[i][15:8] ^ 8'h09;
			mp[1] = ~ROWS[i][3:0];
			tick(2);
			for (int c = 0; c < 2; c++) begin
				m = modem_control_reg[c];
				cmp_b(dtr[c], !m[0]);
				cmp_b(rts[c], feature_control_reg[c][3] | !m[1]);
				cmp_b(op2[c], !m[3]);
				cmp_b(oe[c], m[3]);
				cmp_b(so[c] & !irq[c], 1'b1);
				cmp_v({4'h0, ms[c]}, {4'h0, ~mp[c]});
			end
		end
		cmp_b(cdl[1], 1'b1);
		// receive with auto request: request bit set before auto enable
		{modem_control_reg[0], feature_control_reg[0], interrupt_enable_reg[0], mp[0]} = {8'h0a, 16'h0001, 4'hf};
		tick(1);
		enhanced_feature_reg[0] = 8'h40;
		u_far_a.send(8'h3c);
		wait_rx(0);
		cmp_v(rxd[0], 8'h3c);
		tick(2);
		cmp_b(irq[0] & rts[0], 1'b1);
		rxr[0] = 1'b1;
		tick(1);
		rxr[0] = 1'b0;
		tick(2);
		cmp_b(!rr[0] | irq[0] | rts[0], 1'b0);
		// fill while clear to send is withheld, then drain
		{enhanced_feature_reg[0], interrupt_enable_reg[0]} = 16'h8080;
		for (int i = 0; i < 32; i++) push(0, 8'(i * 37));
		txv[0] = 1'b0;
		tick(200);
		cmp_b(txr[0] | !so[0], 1'b0);
		cmp_v(8'(u_far_a.q.size()), 8'h00);
		mp[0][0] = 1'b0;
		tick(3);
		cmp_b(cdl[0] & irq[0], 1'b1);
		str[0] = 1'b1;
		tick(1);
		str[0] = 1'b0;
		tick(2);
		cmp_b(cdl[0], 1'b0);
		for (k = 0; u_far_a.q.size() < 32; k++) begin
			if (k > 6000) hang();
			tick(1);
		end
		for (int i = 0; i < 32; i++) cmp_v(u_far_a.q[i], 8'(i * 37));
		// infrared on channel b with inverted receive input
		{modem_control_reg[1], feature_control_reg[1]} = 16'h4004;
		tick(2);
		cmp_b(so[1], 1'b0);
		push(1, 8'h0f);
		txv[1] = 1'b0;
		{n, pv} = 0;
		for (int i = 0; i < 200; i++) begin
			if (so[1] && !pv) n++;
			pv = so[1];
			tick(1);
		end
		cmp_v(8'(n), 8'h05);
		u_far_b.send(8'ha5);
		wait_rx(1);
		cmp_v(rxd[1], 8'ha5);
		// half duplex direction on channel b
		{modem_control_reg[1], feature_control_reg[1]} = 16'h0008;
		tick(2);
		push(1, 8'h55);
		txv[1] = 1'b0;
		tick(20);
		cmp_b(rts[1], 1'b0);
		tick(200);
		cmp_b(rts[1], 1'b1);
		cmp_v(u_far_b.q[0], 8'h55);
		test_done();
	end
endmodule // tb
bind usp_modem_pins usp_chk #(.CLKS_PER_BIT(CLKS_PER_BIT)) u_usp_chk (.*);
